// ### mds_pkg.sv
// Purpose: Constants and types for result readout with shadowing.
// Assumes: Byte-wide register reads driven by a host interface front end.
// Notes: Offsets are byte addresses of the result window.
// Notes on behaviour
// - Results occupy one contiguous address range, start to sixth or eighth byte.
// - Pressure and temperature are unsigned 20 bits; humidity unsigned 16 bits.
// - Measurements complete independently of host readout in normal mode.
// - Results completing during a burst go to shadow, visible unchanged.
// - Burst end moves a pending shadow to visible even after a partial read.
// - Burst end is chip select rising in SPI or stop in I2C.
// - All visible result registers update in the same cycle.
package mds_pkg;
    localparam logic [7:0] MDS_ADDR_FIRST = 8'hF7;
    localparam logic [7:0] MDS_ADDR_LAST_TP = 8'hFC;
    localparam logic [7:0] MDS_ADDR_LAST_TPH = 8'hFE;
    localparam logic [7:0] MDS_READ_IDLE = 8'h00;
    localparam logic [19:0] MDS_RESET_TP = 20'h80000;
    localparam logic [15:0] MDS_RESET_H = 16'h8000;
    typedef struct packed {
        logic [19:0] raw_pressure_value;
        logic [19:0] raw_temperature_value;
        logic [15:0] raw_humidity_value;
    } mds_result_t;
    typedef enum logic [1:0] {
        MDS_IDLE = 2'b00,
        MDS_BURST = 2'b01,
        MDS_PEND = 2'b10
    } mds_state_t;
endpackage : mds_pkg

// ### mds_shadow.sv
// Purpose: Visible result registers with shadowing during host bursts.
// Assumes: Interface front end flags I2C burst start and stop; SPI bursts follow the chip select pin.
// Notes: Only the chip select pin is synchronised here; other inputs and strobes are on sys_clk.
module mds_shadow
    import mds_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Measurement side
    input wire logic meas_done,
    input wire mds_pkg::mds_result_t meas_result,
    // Host interface side
    input wire logic spi_mode,
    input wire logic chip_select_low_active,
    input wire logic i2c_burst_start,
    input wire logic i2c_stop_seen,
    input wire logic [7:0] read_addr,
    // Read answer, burst flag and visible results
    output logic [7:0] read_data,
    output logic burst_active,
    output mds_pkg::mds_result_t visible_result
);
    import mds_pkg::*;

    logic cs_meta_q, cs_sync_q, cs_prev_q;
    mds_state_t state_q;
    mds_result_t vis_q, shadow_q;
    logic pend_q, active_q;
    logic [7:0] rdata_q;
    logic cs_rise, cs_fall, burst_end, burst_go, in_burst;

    // Chip select crosses from a pin, so it passes two flops first.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            cs_meta_q <= chip_select_low_active;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    assign cs_rise = cs_sync_q & ~cs_prev_q;
    assign cs_fall = ~cs_sync_q & cs_prev_q;
    assign burst_end = spi_mode ? cs_rise : i2c_stop_seen;
    assign burst_go = spi_mode ? cs_fall : i2c_burst_start;
    assign in_burst = (state_q != MDS_IDLE);

    // The burst flag has its own flop so the output carries no decode behind it.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= MDS_IDLE;
            active_q <= 1'b0;
        end else begin
            case (state_q)
                MDS_IDLE: begin
                    if (burst_go) begin
                        state_q <= MDS_BURST;
                        active_q <= 1'b1;
                    end
                end
                MDS_BURST: begin
                    if (burst_end) begin
                        state_q <= MDS_IDLE;
                        active_q <= 1'b0;
                    end else if (meas_done) begin
                        state_q <= MDS_PEND;
                    end
                end
                MDS_PEND: begin
                    if (burst_end) begin
                        state_q <= MDS_IDLE;
                        active_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= MDS_IDLE;
                    active_q <= 1'b0;
                end
            endcase
        end
    end

    // Latest completion overwrites the shadow; the newest one wins.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shadow_q <= '{MDS_RESET_TP, MDS_RESET_TP, MDS_RESET_H};
            pend_q <= 1'b0;
        end else if (in_burst && meas_done) begin
            shadow_q <= meas_result;
            pend_q <= 1'b1;
        end else if (burst_end || !in_burst) begin
            pend_q <= 1'b0;
        end
    end

    // A completion in the same cycle as burst end is taken directly, so none is lost.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vis_q <= '{MDS_RESET_TP, MDS_RESET_TP, MDS_RESET_H};
        end else if (!in_burst && meas_done) begin
            vis_q <= meas_result;
        end else if (in_burst && burst_end && meas_done) begin
            vis_q <= meas_result;
        end else if (in_burst && burst_end && pend_q) begin
            vis_q <= shadow_q;
        end
    end

    function automatic logic [7:0] mds_byte(input mds_result_t r, input logic [7:0] a);
        logic [7:0] b;
        b = MDS_READ_IDLE;
        case (a - MDS_ADDR_FIRST)
            8'h00: b = r.raw_pressure_value[19:12];
            8'h01: b = r.raw_pressure_value[11:4];
            8'h02: b = {r.raw_pressure_value[3:0], 4'h0};
            8'h03: b = r.raw_temperature_value[19:12];
            8'h04: b = r.raw_temperature_value[11:4];
            8'h05: b = {r.raw_temperature_value[3:0], 4'h0};
            8'h06: b = r.raw_humidity_value[15:8];
            8'h07: b = r.raw_humidity_value[7:0];
            default: b = MDS_READ_IDLE;
        endcase
        return b;
    endfunction : mds_byte

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= MDS_READ_IDLE;
        end else if (read_addr >= MDS_ADDR_FIRST && read_addr <= MDS_ADDR_LAST_TPH) begin
            rdata_q <= mds_byte(vis_q, read_addr);
        end else begin
            rdata_q <= MDS_READ_IDLE;
        end
    end

    assign read_data = rdata_q;
    assign burst_active = active_q;
    assign visible_result = vis_q;

    property p_hold_in_burst;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_burst && !burst_end) |=> $stable(vis_q);
    endproperty
    a_hold_in_burst: assert property (p_hold_in_burst) else $error("visible changed in burst");

    sequence s_pend_end;
        in_burst && pend_q && burst_end && !meas_done;
    endsequence
    property p_copy_at_end;
        @(posedge sys_clk) disable iff (!rst_b)
        s_pend_end |=> (vis_q == $past(shadow_q));
    endproperty
    a_copy_at_end: assert property (p_copy_at_end) else $error("shadow not copied");

    property p_end_idle;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_burst && burst_end) |=> (state_q == MDS_IDLE);
    endproperty
    a_end_idle: assert property (p_end_idle) else $error("burst did not end");

    property p_newest;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_burst && meas_done) |=> (shadow_q == $past(meas_result));
    endproperty
    a_newest: assert property (p_newest) else $error("shadow not newest");

    property p_idle_update;
        @(posedge sys_clk) disable iff (!rst_b)
        (!in_burst && meas_done) |=> (vis_q == $past(meas_result));
    endproperty
    a_idle_update: assert property (p_idle_update) else $error("idle update lost");

    property p_oor_zero;
        @(posedge sys_clk) disable iff (!rst_b)
        (read_addr < MDS_ADDR_FIRST) |=> (read_data == MDS_READ_IDLE);
    endproperty
    a_oor_zero: assert property (p_oor_zero) else $error("out of range read");

    property p_lsb_pad;
        @(posedge sys_clk) disable iff (!rst_b)
        (read_addr == MDS_ADDR_LAST_TP) |=> (read_data[3:0] == 4'h0);
    endproperty
    a_lsb_pad: assert property (p_lsb_pad) else $error("20-bit pad wrong");

    property p_atomic;
        @(posedge sys_clk) disable iff (!rst_b)
        $changed(vis_q) |-> ((vis_q == $past(meas_result)) || (vis_q == $past(shadow_q)));
    endproperty
    a_atomic: assert property (p_atomic) else $error("mixed result set");

    sequence s_start;
        !in_burst && burst_go;
    endsequence
    property p_start;
        @(posedge sys_clk) disable iff (!rst_b)
        s_start |=> burst_active;
    endproperty
    a_start: assert property (p_start) else $error("burst not flagged");

    property p_end_flag;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_burst && burst_end) |=> !burst_active;
    endproperty
    a_end_flag: assert property (p_end_flag) else $error("burst flag stuck");

    property p_direct_end;
        @(posedge sys_clk) disable iff (!rst_b)
        (in_burst && burst_end && meas_done) |=> (vis_q == $past(meas_result));
    endproperty
    a_direct_end: assert property (p_direct_end) else $error("end completion lost");

    // A stale shadow must never be copied again by a later burst.
    property p_pend_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        (!in_burst) |=> !pend_q;
    endproperty
    a_pend_clear: assert property (p_pend_clear) else $error("stale shadow kept");
endmodule : mds_shadow

// ### mds_host_model.sv
// Purpose: Host model that reads the result window in bursts over SPI or I2C.
// Assumes: Requests change 1 ns after the rising edge of sys_clk.
// Notes: The address returns to idle between bursts so read data falls back to MDS_READ_IDLE.
module mds_host_model (
    // Clock
    input wire logic sys_clk,
    // Answer from the device
    input wire logic [7:0] read_data,
    input wire logic burst_active,
    // Requests to the device
    output logic spi_mode,
    output logic chip_select_low_active,
    output logic i2c_burst_start,
    output logic i2c_stop_seen,
    output logic [7:0] read_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    import mds_pkg::*;
    initial begin
        spi_mode = 1'b1;
        chip_select_low_active = 1'b1;
        i2c_burst_start = 1'b0;
        i2c_stop_seen = 1'b0;
        read_addr = MDS_READ_IDLE;
    end
    // Reads between open_burst and close_burst sit inside one burst, so shadowing can keep them consistent.
    task automatic open_burst(input logic spi);
        spi_mode = spi;
        chip_select_low_active = ~spi;
        i2c_burst_start = ~spi;
        @(posedge sys_clk);
        #1 i2c_burst_start = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : open_burst
    // Bytes return raw; the caller compares them with the expected result bytes.
    task automatic fetch(input logic [7:0] addr, output logic [7:0] data);
        read_addr = addr;
        @(posedge sys_clk);
        #1 data = read_data;
    endtask : fetch
    task automatic close_burst(input logic spi);
        read_addr = MDS_READ_IDLE;
        chip_select_low_active = 1'b1;
        i2c_stop_seen = ~spi;
        @(posedge sys_clk);
        #1 i2c_stop_seen = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : close_burst
endmodule : mds_host_model

// ### measurement_data_shadowing_test.sv
// Purpose: Self-checking bench for result shadowing during host bursts.
// Assumes: Host model drives the interface; the bench drives measurements.
// Notes: A queue holds completions seen inside a burst; the newest one wins.
module measurement_data_shadowing_test;
    timeunit 1ns;
    timeprecision 1ns;
    import mds_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic meas_done = 1'b0;
    mds_result_t meas_result = '0;
    logic spi_mode, chip_select_low_active, i2c_burst_start, i2c_stop_seen, burst_active;
    logic [7:0] read_addr, read_data;
    mds_result_t visible_result, exp_vis;
    mds_result_t pend[$];
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    mds_shadow mds_shadow_inst (.sys_clk(sys_clk), .rst_b(rst_b), .meas_done(meas_done),
        .meas_result(meas_result), .spi_mode(spi_mode),
        .chip_select_low_active(chip_select_low_active), .i2c_burst_start(i2c_burst_start),
        .i2c_stop_seen(i2c_stop_seen), .read_addr(read_addr), .read_data(read_data),
        .burst_active(burst_active), .visible_result(visible_result));
    mds_host_model mds_host_model_inst (.sys_clk(sys_clk), .read_data(read_data),
        .burst_active(burst_active), .spi_mode(spi_mode),
        .chip_select_low_active(chip_select_low_active), .i2c_burst_start(i2c_burst_start),
        .i2c_stop_seen(i2c_stop_seen), .read_addr(read_addr));
    always #20 sys_clk = ~sys_clk;
    // A hang is cut short at 3000 cycles, well beyond the fewer than a hundred cycles the run needs.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end
    task automatic results();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic check_vis();
        compares++;
        if (visible_result !== exp_vis) begin
            errors++;
            $display("[FAIL] %0t visible results differ", $time);
        end
    endtask : check_vis
    task automatic check_active(input logic exp);
        compares++;
        if (burst_active !== exp) begin
            errors++;
            $display("[FAIL] %0t burst flag differs", $time);
        end
    endtask : check_active
    task automatic check_byte(input logic [7:0] a);
        logic [7:0] got;
        logic [7:0] exp;
        mds_host_model_inst.fetch(a, got);
        case (a)
            8'hF7: exp = exp_vis.raw_pressure_value[19:12];
            8'hF8: exp = exp_vis.raw_pressure_value[11:4];
            8'hF9: exp = {exp_vis.raw_pressure_value[3:0], 4'h0};
            8'hFA: exp = exp_vis.raw_temperature_value[19:12];
            8'hFB: exp = exp_vis.raw_temperature_value[11:4];
            8'hFC: exp = {exp_vis.raw_temperature_value[3:0], 4'h0};
            8'hFD: exp = exp_vis.raw_humidity_value[15:8];
            8'hFE: exp = exp_vis.raw_humidity_value[7:0];
            default: exp = 8'h00;
        endcase
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t read byte differs", $time);
        end
    endtask : check_byte
    task automatic measure(input logic in_burst);
        meas_result = mds_result_t'({$urandom(), 24'($urandom())});
        meas_done = 1'b1;
        @(posedge sys_clk);
        #1 meas_done = 1'b0;
        if (in_burst)
            pend.push_back(meas_result);
        else
            exp_vis = meas_result;
        // One quiet edge between completions keeps each strobe a separate pulse.
        @(posedge sys_clk);
        #1;
    endtask : measure
    initial begin
        void'($urandom(93));
        exp_vis = {MDS_RESET_TP, MDS_RESET_TP, MDS_RESET_H};
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        check_vis();
        check_active(1'b0);
        // Pass 0 runs I2C with a full read; pass 1 runs SPI and stops after pressure.
        for (int m = 0; m < 2; m++) begin
            measure(1'b0);
            check_vis();
            mds_host_model_inst.open_burst(m[0]);
            check_active(1'b1);
            for (int a = 8'hF6; a <= (m ? 8'hF9 : 8'hFF); a++) begin
                check_byte(8'(a));
                if (a == 8'hF9) begin
                    measure(1'b1);
                    measure(1'b1);
                    check_vis();
                end
            end
            mds_host_model_inst.close_burst(m[0]);
            check_active(1'b0);
            exp_vis = pend[$];
            pend.delete();
            check_vis();
            for (int a = 8'hF7; a <= 8'hFE; a++) check_byte(8'(a));
        end
        // A completion in the very cycle the burst ends beats the older shadow.
        mds_host_model_inst.open_burst(1'b1);
        check_active(1'b1);
        measure(1'b1);
        fork
            mds_host_model_inst.close_burst(1'b1);
            begin
                repeat (2) @(posedge sys_clk);
                #1 measure(1'b0);
            end
        join
        pend.delete();
        check_vis();
        check_active(1'b0);
        for (int a = 8'hF7; a <= 8'hFE; a++) check_byte(8'(a));
        results();
    end
endmodule : measurement_data_shadowing_test
